// *** logic/mac_pkg.sv ***
// Package for the 32-bit multiply-accumulate peripheral.
// Assumes an AXI4-Lite register slave with 32-bit data, one word per register.
package mac_pkg;
   // Byte offsets of the registers
   localparam logic [7:0] OFF_UMUL = 8'h00;
   localparam logic [7:0] OFF_SMUL = 8'h04;
   localparam logic [7:0] OFF_UACC = 8'h08;
   localparam logic [7:0] OFF_SACC = 8'h0c;
   localparam logic [7:0] OFF_OP2N = 8'h10;
   localparam logic [7:0] OFF_RLO = 8'h14;
   localparam logic [7:0] OFF_RHI = 8'h18;
   localparam logic [7:0] OFF_SEXT = 8'h1c;
   localparam logic [7:0] OFF_UMUL_WL = 8'h20;
   localparam logic [7:0] OFF_UMUL_WH = 8'h24;
   localparam logic [7:0] OFF_SMUL_WL = 8'h28;
   localparam logic [7:0] OFF_SMUL_WH = 8'h2c;
   localparam logic [7:0] OFF_UACC_WL = 8'h30;
   localparam logic [7:0] OFF_UACC_WH = 8'h34;
   localparam logic [7:0] OFF_SACC_WL = 8'h38;
   localparam logic [7:0] OFF_SACC_WH = 8'h3c;
   localparam logic [7:0] OFF_SECOND_OPERAND_LOW_HALF = 8'h40;
   localparam logic [7:0] OFF_SECOND_OPERAND_HIGH_HALF = 8'h44;
   localparam logic [7:0] OFF_RESULT_WORD_0 = 8'h48;
   localparam logic [7:0] OFF_RESULT_WORD_1 = 8'h4c;
   localparam logic [7:0] OFF_RESULT_WORD_2 = 8'h50;
   localparam logic [7:0] OFF_RESULT_WORD_3 = 8'h54;
   localparam logic [7:0] OFF_STAT = 8'h58;
   // Status register fields
   localparam int STAT_CARRY_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_WAITH_BIT = 2;
   localparam int STAT_VALID_LSB = 4;
   // Reset values
   localparam logic [31:0] OP_RESET = 32'h0000_0000;
   localparam logic [63:0] RES_RESET = 64'h0;
   // Availability counts in clock cycles after the start write, then extension word values
   localparam logic [3:0] AV_NN_R2 = 4'h4;
   localparam logic [3:0] AV_NN_C = 4'h3;
   localparam logic [3:0] AV_3 = 4'h3;
   localparam logic [3:0] AV_WN_R1 = 4'h5;
   localparam logic [3:0] AV_WN_R2 = 4'h6;
   localparam logic [3:0] AV_WN_R3 = 4'h7;
   localparam logic [3:0] AV_WW_R1 = 4'h8;
   localparam logic [3:0] AV_WW_R2 = 4'ha;
   localparam logic [3:0] AV_WW_R3 = 4'hb;
   localparam logic [3:0] AH_NW_R2 = 4'h4;
   localparam logic [3:0] AH_WW_R2 = 4'h5;
   localparam logic [3:0] AH_WW_R3 = 4'h6;
   localparam logic [15:0] EXT_ONES = 16'hffff;
   localparam logic [15:0] EXT_ONE = 16'h0001;
   // Operation kinds selected by the first-operand address
   typedef enum logic [1:0] {
      MAC_UMUL = 2'b00,
      MAC_SMUL = 2'b01,
      MAC_SACC = 2'b11,
      MAC_UACC = 2'b10
   } mac_kind_t;
   // Write request carried through the decoder
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } mac_wreq_t;
endpackage

// *** logic/mac_top.sv ***
// Multiply and multiply-accumulate peripheral with an AXI4-Lite slave.
// Assumes one clock aclk and a synchronous active-low reset aresetn.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mac_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Write channel holding registers
   logic aw_have_reg;
   logic w_have_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   mac_pkg::mac_wreq_t wreq;
   // Operand state
   logic [31:0] op1_reg;
   logic op1_wide_reg;
   mac_pkg::mac_kind_t kind_reg;
   logic [31:0] op2_reg;
   logic op2_wide_reg;
   logic wait_high_reg;
   // Result state
   logic [63:0] res_reg;
   logic carry_reg;
   logic [15:0] sum_extension_word_reg;
   logic [3:0] word_ok_reg;
   logic carry_ok_reg;
   logic [3:0] cnt_reg;
   logic [3:0] hcnt_reg;
   logic busy_reg;
   logic hbusy_reg;
   logic [63:0] acc_base_reg;
   // Decoded write events
   logic is_byte;
   logic [15:0] wval;
   logic op1_low_wr;
   logic op1_high_wr;
   logic op2n_wr;
   logic second_operand_low_half_wr;
   logic second_operand_high_half_wr;
   logic start;
   logic hstart;
   logic res_wr;
   mac_pkg::mac_kind_t wkind;
   logic [64:0] calc;
   logic calc_carry;
   logic [15:0] calc_ext;
   logic [3:0] word_next;
   logic carry_next;

   // Signedness of a kind
   function automatic logic kind_signed(input mac_pkg::mac_kind_t k);
      return (k == mac_pkg::MAC_SMUL) || (k == mac_pkg::MAC_SACC);
   endfunction

   // Accumulating kind
   function automatic logic kind_acc(input mac_pkg::mac_kind_t k);
      return (k == mac_pkg::MAC_UACC) || (k == mac_pkg::MAC_SACC);
   endfunction

   // Write value from the low half; byte writes use lane 0 only
   function automatic logic [15:0] wr_val(input logic [31:0] d,
                                          input logic byt,
                                          input logic sgn);
      if (byt) begin
         return {{8{sgn & d[7]}}, d[7:0]};
      end
      return d[15:0];
   endfunction

   // AXI write handshake: address and data taken in either order
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign s_axi_bresp = 2'b00;
   assign wreq = '{addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         awaddr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_reg <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_reg <= 1'b0;
      end
   end

   // Write response, one per completed write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Address decode of operand writes
   always_comb begin
      wkind = kind_reg;
      op1_low_wr = 1'b0;
      op1_high_wr = 1'b0;
      case (wreq.addr)
         mac_pkg::OFF_UMUL, mac_pkg::OFF_UMUL_WL: begin
            wkind = mac_pkg::MAC_UMUL;
            op1_low_wr = 1'b1;
         end
         mac_pkg::OFF_SMUL, mac_pkg::OFF_SMUL_WL: begin
            wkind = mac_pkg::MAC_SMUL;
            op1_low_wr = 1'b1;
         end
         mac_pkg::OFF_UACC, mac_pkg::OFF_UACC_WL: begin
            wkind = mac_pkg::MAC_UACC;
            op1_low_wr = 1'b1;
         end
         mac_pkg::OFF_SACC, mac_pkg::OFF_SACC_WL: begin
            wkind = mac_pkg::MAC_SACC;
            op1_low_wr = 1'b1;
         end
         mac_pkg::OFF_UMUL_WH, mac_pkg::OFF_SMUL_WH,
         mac_pkg::OFF_UACC_WH, mac_pkg::OFF_SACC_WH: begin
            op1_high_wr = 1'b1;
         end
         default: begin
            wkind = kind_reg;
         end
      endcase
   end

   // Byte access: lane 0 strobed, lane 1 not; lanes 2 and 3 not looked at
   assign is_byte = (wreq.strb[1:0] == 2'b01);
   assign wval = wr_val(wreq.data, is_byte,
                        kind_signed(op1_low_wr ? wkind : kind_reg));
   assign op2n_wr = wr_fire && (wreq.addr == mac_pkg::OFF_OP2N);
   assign second_operand_low_half_wr = wr_fire && (wreq.addr == mac_pkg::OFF_SECOND_OPERAND_LOW_HALF);
   assign second_operand_high_half_wr = wr_fire && (wreq.addr == mac_pkg::OFF_SECOND_OPERAND_HIGH_HALF)
                    && wait_high_reg;
   assign start = op2n_wr || second_operand_low_half_wr;
   assign hstart = second_operand_high_half_wr;
   assign res_wr = wr_fire && (wreq.addr == mac_pkg::OFF_RESULT_WORD_0 ||
                   wreq.addr == mac_pkg::OFF_RESULT_WORD_1 ||
                   wreq.addr == mac_pkg::OFF_RESULT_WORD_2 ||
                   wreq.addr == mac_pkg::OFF_RESULT_WORD_3 ||
                   wreq.addr == mac_pkg::OFF_RLO ||
                   wreq.addr == mac_pkg::OFF_RHI);

   // First operand store; kept across starts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op1_reg <= mac_pkg::OP_RESET;
         op1_wide_reg <= 1'b0;
         kind_reg <= mac_pkg::MAC_UMUL;
      end else if (wr_fire && op1_low_wr) begin
         op1_reg[15:0] <= wval;
         op1_wide_reg <= 1'b0;
         kind_reg <= wkind;
      end else if (wr_fire && op1_high_wr) begin
         // 24-bit high byte follows the low word's kind
         op1_reg[31:16] <= wval;
         op1_wide_reg <= 1'b1;
      end
   end

   // Second operand store
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op2_reg <= mac_pkg::OP_RESET;
         op2_wide_reg <= 1'b0;
         wait_high_reg <= 1'b0;
      end else if (op2n_wr) begin
         op2_reg[15:0] <= wval;
         op2_wide_reg <= 1'b0;
         wait_high_reg <= 1'b0;
      end else if (second_operand_low_half_wr) begin
         op2_reg[15:0] <= wval;
         op2_wide_reg <= 1'b1;
         wait_high_reg <= 1'b1;
      end else if (second_operand_high_half_wr) begin
         op2_reg[31:16] <= wval;
         wait_high_reg <= 1'b0;
      end
   end

   // Product and accumulation from the held operands
   always_comb begin
      logic sg;
      logic [63:0] a;
      logic [63:0] b;
      logic [63:0] p;
      sg = kind_signed(kind_reg);
      a = op1_wide_reg ? {{32{sg & op1_reg[31]}}, op1_reg}
                       : {{48{sg & op1_reg[15]}}, op1_reg[15:0]};
      b = op2_wide_reg ? {{32{sg & op2_reg[31]}}, op2_reg}
                       : {{48{sg & op2_reg[15]}}, op2_reg[15:0]};
      p = a * b;
      if (!op1_wide_reg && !op2_wide_reg) begin
         // Narrow: 32-bit result decides sign and carry
         calc = kind_acc(kind_reg) ?
                {1'b0, 32'h0, acc_base_reg[31:0]} + {1'b0, 32'h0, p[31:0]}
                : {1'b0, p};
         calc_carry = calc[32];
         if (sg) begin
            calc[63:32] = {32{calc[31]}};
         end else begin
            calc[63:32] = 32'h0;
         end
      end else begin
         calc = kind_acc(kind_reg) ? {1'b0, acc_base_reg} + {1'b0, p}
                                   : {1'b0, p};
         calc_carry = calc[64];
      end
      // Extension word and carry by kind
      case (kind_reg)
         mac_pkg::MAC_UMUL: begin
            calc_ext = 16'h0000;
            calc_carry = 1'b0;
         end
         mac_pkg::MAC_SMUL: begin
            calc_ext = calc[63] ? mac_pkg::EXT_ONES : 16'h0000;
            calc_carry = calc[63];
         end
         mac_pkg::MAC_UACC: begin
            calc_ext = calc_carry ? mac_pkg::EXT_ONE : 16'h0000;
         end
         default: begin
            calc_ext = calc[63] ? mac_pkg::EXT_ONES : 16'h0000;
         end
      endcase
   end

   // Accumulator base: taken at start; unfinished words stay invalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_base_reg <= mac_pkg::RES_RESET;
      end else if (start) begin
         acc_base_reg <= res_reg;
      end
   end

   // Cycle counters from the low and the high start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 4'h0;
         busy_reg <= 1'b0;
      end else if (start) begin
         cnt_reg <= 4'h2; // Taken write edge was cycle 1
         busy_reg <= 1'b1;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg + 4'h1;
         busy_reg <= (cnt_reg < mac_pkg::AV_WW_R3);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hcnt_reg <= 4'h0;
         hbusy_reg <= 1'b0;
      end else if (start) begin
         hcnt_reg <= 4'h0;
         hbusy_reg <= 1'b0;
      end else if (hstart) begin
         hcnt_reg <= 4'h2; // Counted from the taken write
         hbusy_reg <= 1'b1;
      end else if (hbusy_reg) begin
         hcnt_reg <= hcnt_reg + 4'h1;
         hbusy_reg <= (hcnt_reg < mac_pkg::AH_WW_R3);
      end
   end

   // Readiness of each word: later of both points, word 0 from the low start only
   always_comb begin
      logic [3:0] t0, t1, t2, t3, tc, h1, h2, h3, hc;
      logic nn;
      logic hok;
      nn = !op1_wide_reg && !op2_wide_reg;
      t0 = mac_pkg::AV_3;
      h1 = mac_pkg::AV_3;
      t1 = mac_pkg::AV_3; // Narrow figures first
      t2 = mac_pkg::AV_NN_R2;
      t3 = mac_pkg::AV_NN_R2;
      tc = mac_pkg::AV_NN_C;
      if (op1_wide_reg && op2_wide_reg) begin
         t1 = mac_pkg::AV_WW_R1;
         t2 = mac_pkg::AV_WW_R2;
         t3 = mac_pkg::AV_WW_R3;
         tc = mac_pkg::AV_WW_R3;
      end else if (!nn) begin
         t1 = mac_pkg::AV_WN_R1;
         t2 = mac_pkg::AV_WN_R2;
         t3 = mac_pkg::AV_WN_R3;
         tc = mac_pkg::AV_WN_R3;
      end
      h2 = op1_wide_reg ? mac_pkg::AH_WW_R2 : mac_pkg::AH_NW_R2;
      h3 = op1_wide_reg ? mac_pkg::AH_WW_R3 : mac_pkg::AH_NW_R2;
      hc = h3;
      hok = !op2_wide_reg;
      word_next[0] = cnt_reg >= t0;
      word_next[1] = cnt_reg >= t1 && (hok || hcnt_reg >= h1);
      word_next[2] = cnt_reg >= t2 && (hok || hcnt_reg >= h2);
      word_next[3] = cnt_reg >= t3 && (hok || hcnt_reg >= h3);
      carry_next = cnt_reg >= tc && (hok || hcnt_reg >= hc);
   end

   // Result words latch as they become valid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_reg <= mac_pkg::RES_RESET;
         word_ok_reg <= 4'hf;
         carry_ok_reg <= 1'b1;
         carry_reg <= 1'b0;
         sum_extension_word_reg <= 16'h0000;
      end else if (start) begin
         word_ok_reg <= 4'h0;
         carry_ok_reg <= 1'b0;
      end else if (res_wr && !busy_reg) begin
         case (wreq.addr)
            mac_pkg::OFF_RESULT_WORD_0, mac_pkg::OFF_RLO: res_reg[15:0] <= wval;
            mac_pkg::OFF_RESULT_WORD_1, mac_pkg::OFF_RHI: res_reg[31:16] <= wval;
            mac_pkg::OFF_RESULT_WORD_2: res_reg[47:32] <= wval;
            default: res_reg[63:48] <= wval;
         endcase
      end else if (busy_reg || hbusy_reg) begin
         for (int i = 0; i < 4; i++) begin
            if (word_next[i] && !word_ok_reg[i]) begin
               res_reg[i*16 +: 16] <= calc[i*16 +: 16];
               word_ok_reg[i] <= 1'b1;
            end
         end
         if (carry_next && !carry_ok_reg) begin
            carry_reg <= calc_carry;
            sum_extension_word_reg <= calc_ext;
            carry_ok_reg <= 1'b1;
         end
      end
   end

   // AXI read: one-cycle answer from registered data
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp = 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            mac_pkg::OFF_UMUL, mac_pkg::OFF_SMUL, mac_pkg::OFF_UACC,
            mac_pkg::OFF_SACC, mac_pkg::OFF_UMUL_WL, mac_pkg::OFF_SMUL_WL,
            mac_pkg::OFF_UACC_WL, mac_pkg::OFF_SACC_WL:
               s_axi_rdata <= {16'h0000, op1_reg[15:0]};
            mac_pkg::OFF_UMUL_WH, mac_pkg::OFF_SMUL_WH,
            mac_pkg::OFF_UACC_WH, mac_pkg::OFF_SACC_WH:
               s_axi_rdata <= {16'h0000, op1_reg[31:16]};
            mac_pkg::OFF_OP2N, mac_pkg::OFF_SECOND_OPERAND_LOW_HALF:
               s_axi_rdata <= {16'h0000, op2_reg[15:0]};
            mac_pkg::OFF_SECOND_OPERAND_HIGH_HALF: s_axi_rdata <= {16'h0000, op2_reg[31:16]};
            mac_pkg::OFF_RESULT_WORD_0, mac_pkg::OFF_RLO:
               s_axi_rdata <= {16'h0000, res_reg[15:0]};
            mac_pkg::OFF_RESULT_WORD_1, mac_pkg::OFF_RHI:
               s_axi_rdata <= {16'h0000, res_reg[31:16]};
            mac_pkg::OFF_RESULT_WORD_2: s_axi_rdata <= {16'h0000, res_reg[47:32]};
            mac_pkg::OFF_RESULT_WORD_3: s_axi_rdata <= {16'h0000, res_reg[63:48]};
            mac_pkg::OFF_SEXT: s_axi_rdata <= {16'h0000, sum_extension_word_reg};
            mac_pkg::OFF_STAT: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rdata[mac_pkg::STAT_CARRY_BIT] <= carry_reg;
               s_axi_rdata[mac_pkg::STAT_BUSY_BIT] <= busy_reg | hbusy_reg;
               s_axi_rdata[mac_pkg::STAT_WAITH_BIT] <= wait_high_reg;
               s_axi_rdata[mac_pkg::STAT_VALID_LSB +: 4] <= word_ok_reg;
            end
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** verif/mac_sva.sv ***
// Bus checker for the multiply-accumulate peripheral.
// Assumes it is bound to mac_top and sees only its AXI4-Lite ports.
`timescale 1ns/1ns
`default_nettype none
module mac_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Responses and handshake relations
   a_bresp_okay: assert property (
      s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("bad bresp");
   a_rresp_okay: assert property (
      s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("bad rresp");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_b_blocks_take: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   a_r_blocks_take: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   a_b_after_held: assert property (
      $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
      else $error("stray write answer");
   a_one_write: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_one_read: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
endmodule
bind mac_top mac_chk chk (.*);
`default_nettype wire

// *** verif/mac_host.sv ***
// Host model issuing AXI4-Lite accesses to the multiplier.
// Assumes one access at a time; a stuck access ends the run.
`timescale 1ns/1ns
`default_nettype none
module mac_host (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
      s_axi_wdata = 32'h0;
   end
   // Write; strobe 1 is a byte access, f a word access
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic [3:0] s);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 40) mac_top_tb_top.hang();
   endtask
   // Read one word
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk); // One idle edge before the request
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (n == 40) mac_top_tb_top.hang();
   endtask
endmodule
`default_nettype wire

// *** verif/mac_top_tb_top.sv ***
// Self-checking bench for the multiply-accumulate peripheral.
// Assumes mac_top, mac_host and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module mac_top_tb_top;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int fail_count, comparisons;
   logic [63:0] p;
   mac_top uut (.*);
   mac_host host (.*);
   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang();
      fail_count++;
      wrap_up();
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e,
      input string nm);
      logic [31:0] d;
      host.rd(a, d);
      chk(nm, e, d[15:0]);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host.wr(a, d, 4'hf);
   endtask
   // One status bit
   task automatic rs(input int b, input logic e, input string nm);
      logic [31:0] d;
      host.rd(mac_pkg::OFF_STAT, d);
      chk(nm, {15'h0, e}, {15'h0, d[b]});
   endtask
   // All four result words, lowest first
   task automatic res4(input logic [63:0] e);
      for (int i = 0; i < 4; i++)
         rc(mac_pkg::OFF_RESULT_WORD_0 + 8'(4 * i), e[16 * i +: 16], "result word");
   endtask
   // Wait until the multiplier is no longer busy
   task automatic idle();
      logic [31:0] d;
      d = 32'h2;
      for (int n = 0; n < 20 && d[1] !== 1'b0; n++)
         host.rd(mac_pkg::OFF_STAT, d);
      if (d[1] !== 1'b0) hang();
   endtask
   initial begin
      aresetn = 1'b0;
      fail_count = 0;
      comparisons = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      res4(64'h0);
      rc(mac_pkg::OFF_STAT, 16'h00f0, "status");
      // Unsigned 16x16, read at once
      wr(mac_pkg::OFF_UMUL, 16'h1234);
      wr(mac_pkg::OFF_OP2N, 16'h5678);
      p = 64'h1234 * 64'h5678;
      rc(mac_pkg::OFF_RLO, p[15:0], "low");
      rc(mac_pkg::OFF_RHI, p[31:16], "high");
      rc(mac_pkg::OFF_SEXT, 16'h0, "ext");
      rs(0, 1'b0, "carry");
      // Signed multiply, then reuse of the first operand
      wr(mac_pkg::OFF_SMUL, 16'hffff);
      wr(mac_pkg::OFF_OP2N, 16'h0003);
      res4(-64'sd3);
      rc(mac_pkg::OFF_SEXT, 16'hffff, "ext");
      rs(0, 1'b1, "sign");
      wr(mac_pkg::OFF_OP2N, 16'h0002);
      rc(mac_pkg::OFF_RLO, 16'hfffe, "reuse");
      // Signed byte operand
      host.wr(mac_pkg::OFF_SMUL, 16'h0080, 4'h1);
      wr(mac_pkg::OFF_OP2N, 16'h0002);
      rc(mac_pkg::OFF_RHI, 16'hffff, "byte high");
      rc(mac_pkg::OFF_RLO, 16'hff00, "byte low");
      // Unsigned accumulate with carry
      wr(mac_pkg::OFF_UMUL, 16'h0000);
      wr(mac_pkg::OFF_OP2N, 16'h0000);
      wr(mac_pkg::OFF_UACC, 16'hffff);
      wr(mac_pkg::OFF_OP2N, 16'hffff);
      wr(mac_pkg::OFF_OP2N, 16'hffff);
      rc(mac_pkg::OFF_RLO, 16'h0002, "acc low");
      rc(mac_pkg::OFF_RHI, 16'hfffc, "acc high");
      rc(mac_pkg::OFF_SEXT, 16'h0001, "acc ext");
      rs(0, 1'b1, "acc carry");
      // Signed accumulate of negative products
      wr(mac_pkg::OFF_SMUL, 16'h0000);
      wr(mac_pkg::OFF_OP2N, 16'h0000);
      wr(mac_pkg::OFF_SACC, 16'hffff);
      wr(mac_pkg::OFF_OP2N, 16'h0002);
      wr(mac_pkg::OFF_OP2N, 16'h0002);
      rc(mac_pkg::OFF_RLO, 16'hfffc, "sacc low");
      rc(mac_pkg::OFF_SEXT, 16'hffff, "sacc ext");
      rs(0, 1'b1, "sacc carry");
      // Wide 32x32 with the second operand in two halves
      wr(mac_pkg::OFF_UMUL_WL, 16'h5678);
      wr(mac_pkg::OFF_UMUL_WH, 16'h1234);
      wr(mac_pkg::OFF_SECOND_OPERAND_LOW_HALF, 16'hdef0);
      rs(mac_pkg::STAT_WAITH_BIT, 1'b1, "await high");
      wr(mac_pkg::OFF_SECOND_OPERAND_HIGH_HALF, 16'h9abc);
      idle();
      p = 64'h1234_5678 * 64'h9abc_def0;
      res4(p);
      rs(mac_pkg::STAT_WAITH_BIT, 1'b0, "high taken");
      // Lone high half leaves the result alone
      wr(mac_pkg::OFF_SECOND_OPERAND_HIGH_HALF, 16'h1111);
      idle();
      res4(p);
      // High word written first is ignored
      wr(mac_pkg::OFF_UMUL_WH, 16'hffff);
      wr(mac_pkg::OFF_UMUL_WL, 16'h0003);
      wr(mac_pkg::OFF_OP2N, 16'h0005);
      rc(mac_pkg::OFF_RLO, 16'h000f, "narrow low");
      rc(mac_pkg::OFF_RHI, 16'h0000, "narrow high");
      // Narrow start aborts a wide one
      wr(mac_pkg::OFF_SECOND_OPERAND_LOW_HALF, 16'h0007);
      wr(mac_pkg::OFF_OP2N, 16'h0004);
      idle();
      res4(64'hc);
      // Signed 24-bit operand: word low, byte high
      wr(mac_pkg::OFF_SMUL_WL, 16'h0000);
      host.wr(mac_pkg::OFF_SMUL_WH, 16'h0080, 4'h1);
      wr(mac_pkg::OFF_OP2N, 16'h0002);
      idle();
      res4(64'hffff_ffff_ff00_0000);
      // Result word written only once the unit is idle
      wr(mac_pkg::OFF_RESULT_WORD_2, 16'h1357);
      rc(mac_pkg::OFF_RESULT_WORD_2, 16'h1357, "result write");
      // Unmapped places
      rc(8'hfc, 16'h0, "unmapped");
      wr(8'hfc, 16'h1234);
      rc(mac_pkg::OFF_RESULT_WORD_1, 16'hff00, "kept");
      wrap_up();
   end
endmodule
`default_nettype wire
